// file: acc_params.svh
// Register offsets, field positions, reset values and masks of the ADC conversion control
// Overview of operation
// [RULE1] A write changing any writable bit of either control register aborts a conversion.
// [RULE2] Bit 20 set holds the converter in reset when powered down, else standby.
// [RULE3] Bit 17 set selects single-cycle conversion; clear selects continuous with latency.
// [RULE4] Bit 16 clear: one conversion then standby; set: repeated single-cycle conversions. With bit 20 set the code holds reset, not standby, once done.
// [RULE5] The repeat bit acts only while single-cycle select is one.
// [RULE6] Bit 23 picks the external clock pin when set, internal oscillator when clear.
// [RULE7] Bit 21 set enables synchronisation of conversions by the sync pin.
// [RULE8] Bit 19 set corrects every channel as if gain were 0x800000.
// [RULE9] Bit 18 set corrects every channel as if offset were zero.
// [RULE10] Result register is read-only, 24-bit two's complement, resets to zero.
// [RULE11] Reading the result register clears the result-ready flag.
// [RULE12] Mode 01 is power-down, 11 is conversion; 00 and 10 are reserved.
// [RULE13] An aborted conversion neither updates the result nor sets result-ready.
`ifndef ACC_PARAMS_SVH
`define ACC_PARAMS_SVH

`define ACC_ADDR_CTRL_ONE     8'h22
`define ACC_ADDR_CTRL_TWO     8'h23
`define ACC_ADDR_RESULT       8'h24

`define ACC_BIT_PD_DEPTH      20
`define ACC_BIT_SINGLE        17
`define ACC_BIT_REPEAT        16
`define ACC_BIT_EXT_CLK       23
`define ACC_BIT_SYNC_EN       21
`define ACC_BIT_GAIN_BYP      19
`define ACC_BIT_OFFS_BYP      18

`define ACC_MASK_CTRL_ONE     24'h130000
`define ACC_MASK_CTRL_TWO     24'hac0000
`define ACC_RST_CTRL_ONE      24'h020000
`define ACC_RST_CTRL_TWO      24'h000000
`define ACC_RST_RESULT        24'h000000

`define ACC_UNITY_GAIN        24'h800000
`define ACC_ZERO_OFFSET       24'h000000
`define ACC_GAIN_SHIFT        23

`define ACC_MODE_POWERDOWN    2'h1
`define ACC_MODE_CONVERT      2'h3

`endif

// file: acc_pkg.sv
// Types shared by the ADC conversion control block
package acc_pkg;

    typedef logic [23:0] acc_word_t;

    typedef enum logic [1:0] {
        ACC_IDLE,
        ACC_WAIT_SYNC,
        ACC_CONVERT,
        ACC_DONE
    } acc_state_e;

endpackage

// file: acc_correct.sv
// System gain and offset correction of one raw converter sample
`timescale 1ns/10ps
`include "acc_params.svh"

module acc_correct
    import acc_pkg::*;
(
    // Raw sample and coefficients
    input  wire acc_pkg::acc_word_t raw_i,
    input  wire acc_pkg::acc_word_t gain_i,
    input  wire acc_pkg::acc_word_t offset_i,
    input  wire logic               gain_byp_i,
    input  wire logic               offs_byp_i,
    // Corrected sample
    output logic [23:0]             result_o
);
    import acc_pkg::*;

    logic [23:0]        gain_eff;
    logic [23:0]        offs_eff;
    logic signed [24:0] diff;
    logic signed [49:0] prod;
    logic signed [49:0] scaled;

    always_comb
    begin
        gain_eff = gain_byp_i ? `ACC_UNITY_GAIN : gain_i;   // [RULE8]
        offs_eff = offs_byp_i ? `ACC_ZERO_OFFSET : offset_i; // [RULE9]
        diff     = $signed({raw_i[23], raw_i}) - $signed({offs_eff[23], offs_eff});
        prod     = 50'(diff) * $signed({25'h0000000, gain_eff});
        scaled   = prod >>> `ACC_GAIN_SHIFT;
        // Saturate so an overrange sample clips instead of wrapping sign
        if (scaled > 50'sh00000007fffff)
        begin
            result_o = 24'h7fffff;
        end
        else if (scaled < -50'sh0000000800000)
        begin
            result_o = 24'h800000;
        end
        else
        begin
            result_o = scaled[23:0];
        end
    end

endmodule

// file: acc_ctrl.sv
// ADC conversion control, result register and conversion sequencer
`timescale 1ns/10ps
`include "acc_params.svh"

module acc_ctrl
    import acc_pkg::*;
(
    // Clock and reset
    input  wire logic               mclk_i,
    input  wire logic               rst_b_i,
    // Register access from the serial front end
    input  wire logic [7:0]         reg_addr_i,
    input  wire logic               reg_wr_i,
    input  wire logic               reg_rd_i,
    input  wire acc_pkg::acc_word_t reg_wdata_i,
    output acc_pkg::acc_word_t      reg_rdata_o,
    // Mode field, sync pin and coefficients of the selected channel
    input  wire logic [1:0]         converter_operating_mode_i,
    input  wire logic               sync_i,
    input  wire acc_pkg::acc_word_t system_gain_coefficient_i,
    input  wire acc_pkg::acc_word_t system_offset_coefficient_i,
    // Modulator and filter
    input  wire logic               raw_valid_i,
    input  wire acc_pkg::acc_word_t raw_data_i,
    output logic                    conv_run_o,
    output logic                    conv_abort_o,
    output logic                    continuous_o,
    output logic                    adc_standby_o,
    output logic                    adc_reset_o,
    output logic                    external_clock_select_o,
    output logic                    sync_enable_o,
    // Status
    output logic                    result_ready_o
);
    import acc_pkg::*;

    typedef struct packed {
        acc_state_e state;
        acc_word_t  ctrl_one;
        acc_word_t  ctrl_two;
        acc_word_t  result;
        acc_word_t  rdata;
        logic       ready;
        logic       abort;
    } acc_regs_s;

    acc_regs_s   r;
    acc_regs_s   next_r;
    logic [23:0] corrected;
    logic        wr_one;
    logic        wr_two;
    logic        changed;
    logic        single;
    logic        repeat_on;
    logic        mode_conv;
    logic        result_rd;

    acc_correct u_correct (
        .raw_i      (raw_data_i),
        .gain_i     (system_gain_coefficient_i),
        .offset_i   (system_offset_coefficient_i),
        .gain_byp_i (r.ctrl_two[`ACC_BIT_GAIN_BYP]),
        .offs_byp_i (r.ctrl_two[`ACC_BIT_OFFS_BYP]),
        .result_o   (corrected)
    );

    always_comb
    begin
        next_r    = r;
        wr_one    = reg_wr_i && (reg_addr_i == `ACC_ADDR_CTRL_ONE);
        wr_two    = reg_wr_i && (reg_addr_i == `ACC_ADDR_CTRL_TWO);
        result_rd = reg_rd_i && (reg_addr_i == `ACC_ADDR_RESULT);
        changed   = (wr_one && ((reg_wdata_i ^ r.ctrl_one) & `ACC_MASK_CTRL_ONE) != 24'h000000)
                 || (wr_two && ((reg_wdata_i ^ r.ctrl_two) & `ACC_MASK_CTRL_TWO) != 24'h000000);
        single    = r.ctrl_one[`ACC_BIT_SINGLE];
        repeat_on = single && r.ctrl_one[`ACC_BIT_REPEAT];             // [RULE5]
        mode_conv = (converter_operating_mode_i == `ACC_MODE_CONVERT); // [RULE12]

        // Reserved bits are never stored, so they always read as zero
        if (wr_one)
        begin
            next_r.ctrl_one = reg_wdata_i & `ACC_MASK_CTRL_ONE;
        end
        if (wr_two)
        begin
            next_r.ctrl_two = reg_wdata_i & `ACC_MASK_CTRL_TWO;
        end

        next_r.rdata = r.rdata;
        if (reg_rd_i)
        begin
            unique case (reg_addr_i)
                `ACC_ADDR_CTRL_ONE: next_r.rdata = r.ctrl_one;
                `ACC_ADDR_CTRL_TWO: next_r.rdata = r.ctrl_two;
                `ACC_ADDR_RESULT:   next_r.rdata = r.result; // [RULE10]
                default:            next_r.rdata = 24'h000000;
            endcase
        end

        if (result_rd)
        begin
            next_r.ready = 1'b0; // [RULE11]
        end

        next_r.abort = 1'b0;
        if (changed && (r.state == ACC_CONVERT || r.state == ACC_WAIT_SYNC))
        begin
            // Back to idle so the new settings pick the next state; sample dropped
            next_r.abort = 1'b1; // [RULE1]
            next_r.state = ACC_IDLE; // [RULE13]
        end
        else if (!mode_conv)
        begin
            next_r.state = ACC_IDLE;
        end
        else
        begin
            unique case (r.state)
                ACC_IDLE:
                begin
                    next_r.state = r.ctrl_two[`ACC_BIT_SYNC_EN] ? ACC_WAIT_SYNC
                                                                : ACC_CONVERT; // [RULE7]
                end
                ACC_WAIT_SYNC:
                begin
                    if (sync_i)
                    begin
                        next_r.state = ACC_CONVERT; // [RULE7]
                    end
                end
                ACC_CONVERT:
                begin
                    if (raw_valid_i)
                    begin
                        next_r.result = corrected;
                        next_r.ready  = 1'b1; // New sample wins over a same-cycle read
                        if (single && !repeat_on)
                        begin
                            next_r.state = ACC_DONE; // [RULE4]
                        end
                    end
                end
                ACC_DONE:
                begin
                    next_r.state = ACC_DONE; // Leaves only when the mode drops out of 11
                end
            endcase
        end
    end

    always_ff @(posedge mclk_i or negedge rst_b_i)
    begin
        if (!rst_b_i)
        begin
            r.state    <= ACC_IDLE;
            r.ctrl_one <= `ACC_RST_CTRL_ONE;
            r.ctrl_two <= `ACC_RST_CTRL_TWO;
            r.result   <= `ACC_RST_RESULT; // [RULE10]
            r.rdata    <= 24'h000000;
            r.ready    <= 1'b0;
            r.abort    <= 1'b0;
        end
        else
        begin
            r <= next_r;
        end
    end

    assign reg_rdata_o             = r.rdata;
    assign result_ready_o          = r.ready;
    assign conv_abort_o            = r.abort;
    assign conv_run_o              = (r.state == ACC_CONVERT);
    assign continuous_o            = !r.ctrl_one[`ACC_BIT_SINGLE]; // [RULE3]
    assign external_clock_select_o = r.ctrl_two[`ACC_BIT_EXT_CLK]; // [RULE6]
    assign sync_enable_o           = r.ctrl_two[`ACC_BIT_SYNC_EN];
    // Power-down depth only matters when not converting
    assign adc_reset_o   = (r.state != ACC_CONVERT) && r.ctrl_one[`ACC_BIT_PD_DEPTH];  // [RULE2]
    assign adc_standby_o = (r.state != ACC_CONVERT) && !r.ctrl_one[`ACC_BIT_PD_DEPTH]; // [RULE2]

endmodule

// file: acc_ctrl_properties.sv
// Port checks of the conversion control block
`timescale 1ns/10ps
module acc_ctrl_properties
    import acc_pkg::*;
(
    input wire logic       mclk_i,
    input wire logic       rst_b_i,
    input wire logic [7:0] reg_addr_i,
    input wire logic       reg_wr_i,
    input wire logic       reg_rd_i,
    input wire logic [1:0] converter_operating_mode_i,
    input wire logic       sync_i,
    input wire logic       raw_valid_i,
    input wire acc_word_t  reg_rdata_o,
    input wire logic       conv_run_o,
    input wire logic       conv_abort_o,
    input wire logic       adc_standby_o,
    input wire logic       adc_reset_o,
    input wire logic       sync_enable_o,
    input wire logic       result_ready_o
);
    default clocking cb @(posedge mclk_i); endclocking
    default disable iff (!rst_b_i);
    a_abort_stops_run: assert property (conv_abort_o |-> !conv_run_o)
        else $error("run in abort");
    a_depth_exclusive: assert property (!(adc_standby_o && adc_reset_o))
        else $error("depth");
    a_run_needs_mode: assert property ($rose(conv_run_o) |->
        $past(converter_operating_mode_i) == 2'h3) else $error("run without mode");
    a_read_clears: assert property (reg_rd_i && reg_addr_i == 8'h24 && !raw_valid_i
        |=> !result_ready_o) else $error("ready kept");
    a_abort_no_ready: assert property (conv_abort_o |-> !$rose(result_ready_o))
        else $error("ready");
    // A sample is only taken while the mode field still asks for conversion
    a_sample_ready: assert property (conv_run_o && raw_valid_i && !reg_wr_i
        && converter_operating_mode_i == 2'h3 |=> result_ready_o) else $error("no ready");
    a_rdata_holds: assert property (!reg_rd_i |=> $stable(reg_rdata_o))
        else $error("rdata moved");
    a_sync_waits: assert property (sync_enable_o && !sync_i && !conv_run_o && !reg_wr_i
        |=> !conv_run_o) else $error("no sync wait");
    cover property (conv_abort_o);
    cover property ($rose(result_ready_o));
    cover property (sync_enable_o && $rose(conv_run_o));
endmodule
bind acc_ctrl acc_ctrl_properties u_acc_ctrl_properties (.mclk_i, .rst_b_i, .reg_addr_i,
    .reg_wr_i, .reg_rd_i, .converter_operating_mode_i, .sync_i, .raw_valid_i, .reg_rdata_o,
    .conv_run_o, .conv_abort_o, .adc_standby_o, .adc_reset_o, .sync_enable_o, .result_ready_o);

// file: acc_filter_model.sv
// Filter model giving one raw sample every gap_i cycles of conversion
`timescale 1ns/10ps
module acc_filter_model (
    input  wire logic        mclk_i,
    input  wire logic        conv_run_i,
    input  wire logic [7:0]  gap_i,
    input  wire logic [23:0] data_i,
    output logic             raw_valid_o,
    output logic [23:0]      raw_data_o
);
    logic [7:0] cnt = 8'h00;
    initial raw_valid_o = 1'b0;
    initial raw_data_o = 24'h000000;
    // Gap zero stalls; data is inverted outside valid so stale words cannot pass
    always @(negedge mclk_i)
    begin
        cnt = conv_run_i ? cnt + 8'h01 : 8'h00;
        raw_valid_o = conv_run_i && gap_i != 8'h00 && cnt == gap_i;
        raw_data_o = raw_valid_o ? data_i : ~data_i;
        if (raw_valid_o)
            cnt = 8'h00;
    end
endmodule

// file: testbench.sv
// Testbench of the ADC conversion control block
`timescale 1ns/10ps
module testbench;
    import acc_pkg::*;
    logic      mclk_i = 0, rst_b_i = 0, reg_wr_i = 0, reg_rd_i = 0, sync_i = 0;
    logic      raw_valid_i, conv_run_o, conv_abort_o, continuous_o, adc_standby_o;
    logic      adc_reset_o, external_clock_select_o, sync_enable_o, result_ready_o;
    logic [7:0] reg_addr_i = 8'h00, gap = 8'h00;
    logic [1:0] converter_operating_mode_i = 2'h1;
    acc_word_t reg_wdata_i = '0, raw = '0, reg_rdata_o, raw_data_i;
    acc_word_t system_gain_coefficient_i = 24'h400000, system_offset_coefficient_i = 24'h000010;
    int        failures = 0, compares = 0, cycles = 0;
    acc_ctrl u_acc_ctrl (.mclk_i, .rst_b_i, .reg_addr_i, .reg_wr_i, .reg_rd_i, .reg_wdata_i,
        .reg_rdata_o, .converter_operating_mode_i, .sync_i, .system_gain_coefficient_i,
        .system_offset_coefficient_i, .raw_valid_i, .raw_data_i, .conv_run_o, .conv_abort_o,
        .continuous_o, .adc_standby_o, .adc_reset_o, .external_clock_select_o,
        .sync_enable_o, .result_ready_o);
    acc_filter_model u_acc_filter_model (.mclk_i, .conv_run_i(conv_run_o), .gap_i(gap),
        .data_i(raw), .raw_valid_o(raw_valid_i), .raw_data_o(raw_data_i));
    always #2.5 mclk_i = ~mclk_i;
    task automatic conclude();
        $display("compares %0d failures %0d", compares, failures);
        if (failures == 0 && compares > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask
    // Whole run needs about 200 cycles
    always @(posedge mclk_i)
    begin
        cycles++;
        if (cycles == 20000)
        begin
            failures++;
            conclude();
        end
    end
    task automatic chk(string n, logic [23:0] s, logic [23:0] e);
        compares++;
        if (s !== e)
        begin
            failures++;
            $display("BAD %s exp %h got %h", n, e, s);
        end
    endtask
    task automatic acc(logic [7:0] a, logic w, acc_word_t d);
        @(negedge mclk_i);
        reg_addr_i = a;
        reg_wr_i = w;
        reg_rd_i = !w;
        reg_wdata_i = d;
        @(negedge mclk_i);
        reg_wr_i = 0;
        reg_rd_i = 0;
    endtask
    task automatic rd(logic [7:0] a, acc_word_t e);
        acc(a, 0, '0);
        chk("rdata", reg_rdata_o, e);
    endtask
    task automatic t_regs();
        rd(8'h22, 24'h020000);
        rd(8'h23, 24'h000000);
        rd(8'h30, 24'h000000);
        chk("standby", adc_standby_o, 1);
        acc(8'h22, 1, 24'hffffff);
        rd(8'h22, 24'h130000);
        chk("reset", adc_reset_o, 1);
        chk("cont", continuous_o, 0);
        acc(8'h23, 1, 24'hffffff);
        rd(8'h23, 24'hac0000);
        chk("ext", external_clock_select_o, 1);
        chk("sync", sync_enable_o, 1);
        acc(8'h24, 1, 24'h5a5a5a);
        rd(8'h24, 24'h000000);
        $display("t_regs done");
    endtask
    task automatic conv(acc_word_t c1, acc_word_t c2, acc_word_t e, logic run);
        converter_operating_mode_i = 2'h1;
        acc(8'h22, 1, c1);
        acc(8'h23, 1, c2);
        converter_operating_mode_i = 2'h3;
        for (int i = 0; i < 200 && result_ready_o !== 1'b1; i++)
            @(negedge mclk_i);
        rd(8'h24, e);
        chk("ready", result_ready_o, 0);
        chk("run", conv_run_o, run);
        chk("idle", adc_standby_o, !run);
    endtask
    task automatic t_conv();
        gap = 8'd20;
        raw = 24'h000210;
        conv(24'h020000, 24'h0c0000, 24'h000210, 0);
        conv(24'h020000, 24'h000000, 24'h000100, 0);
        conv(24'h030000, 24'h080000, 24'h000200, 1);
        conv(24'h000000, 24'h040000, 24'h000108, 1);
        conv(24'h010000, 24'h0c0000, 24'h000210, 1);
        chk("cont5", continuous_o, 1);
        $display("t_conv done");
    endtask
    task automatic t_abort();
        gap = 8'h00;
        repeat (3) @(negedge mclk_i);
        acc(8'h22, 1, 24'h100000);
        chk("abort", conv_abort_o, 1);
        chk("run0", conv_run_o, 0);
        chk("noready", result_ready_o, 0);
        acc(8'h22, 1, 24'h100000);
        chk("same", conv_abort_o, 0);
        acc(8'h23, 1, 24'h200000);
        chk("abort2", conv_abort_o, 1);
        repeat (4) @(negedge mclk_i);
        chk("waitsync", conv_run_o, 0);
        sync_i = 1;
        repeat (2) @(negedge mclk_i);
        chk("synced", conv_run_o, 1);
        // A reserved mode code must stop the converter like power-down
        converter_operating_mode_i = 2'h2;
        repeat (2) @(negedge mclk_i);
        chk("rsvmode", conv_run_o, 0);
        chk("pdreset", adc_reset_o, 1);
        converter_operating_mode_i = 2'h1;
        $display("t_abort done");
    endtask
    initial
    begin
        repeat (12) @(negedge mclk_i);
        rst_b_i = 1;
        t_regs();
        t_conv();
        t_abort();
        conclude();
    end
endmodule
